// ### cia_defines.vh
// register map, field positions and reset values of the interrupt aggregator
`ifndef CIA_DEFINES_VH
`define CIA_DEFINES_VH
`define CIA_ADDR_W 12
`define CIA_REG_DRC_CFG 12'h540
`define CIA_REG_FLAG1 12'h730
`define CIA_REG_FLAG2 12'h731
`define CIA_REG_RAW2 12'h732
`define CIA_REG_MASK1 12'h738
`define CIA_REG_MASK2 12'h739
`define CIA_REG_CTRL 12'h740
`define CIA_REG_DEBOUNCE 12'h748
`define CIA_REG_GPIO_SEL 12'h741
`define CIA_DRC_RMS_HI 15
`define CIA_DRC_RMS_LO 11
`define CIA_DRC_PK_HI 10
`define CIA_DRC_PK_LO 9
`define CIA_DRC_MODE_BIT 7
`define CIA_DRC_ENA_BIT 6
`define CIA_DRC_CFG_RST 16'h0080
`define CIA_DRC_CFG_MASK 16'hFEC0
`define CIA_FLAG1_MASK 16'h07A1
`define CIA_FLAG2_MASK 16'hDBE3
`define CIA_MASK_RST 16'hFFFF
`define CIA_CTRL_GMASK_BIT 0
`define CIA_DB_SHUT_BIT 0
`define CIA_DB_WARN_BIT 1
`define CIA_GPIO_FN_IRQ 2'h1
`define CIA_GPIO_FN_FIFO 2'h2
`define CIA_DB_TIME_US 4
`define CIA_CLK_MHZ 25
`define CIA_DB_CYCLES (`CIA_DB_TIME_US * `CIA_CLK_MHZ)
`endif

// ### cia_edge_cell.v
// one interrupt input: synchroniser, optional debounce, edge detect, sticky flag
`timescale 1ns/1ps
`default_nettype none
module cia_edge_cell #(
  parameter BOTH_EDGES = 1,
  parameter DB_CYCLES = 100
) (
  input wire ref_clk,
  input wire rstn,
  input wire src_async,
  input wire db_enable,
  input wire clear,
  output reg flag,
  output wire level
);
  // ===========================================
  // synchroniser and debounce
  reg sync_a;
  reg sync_b;
  reg stable;
  reg prev;
  reg [7:0] db_count;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= src_async;
      sync_b <= sync_a;
    end
  end
  // with debounce enabled, the filtered level only moves once the input has held for the full window; disabled, it follows sync_b
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      stable <= 1'b0;
      db_count <= 8'h00;
    end else if (!db_enable || sync_b == stable) begin
      db_count <= 8'h00;
      if (!db_enable) begin
        stable <= sync_b;
      end
    end else if (db_count >= DB_CYCLES[7:0] - 8'h01) begin
      stable <= sync_b;
      db_count <= 8'h00;
    end else begin
      db_count <= db_count + 8'h01;
    end
  end
  assign level = stable;
  // ===========================================
  // edge detect and sticky flag
  wire rise = stable & ~prev;
  wire fall = ~stable & prev;
  wire hit = rise | ((BOTH_EDGES != 0) & fall);
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      prev <= 1'b0;
      flag <= 1'b0;
    end else begin
      prev <= stable;
      if (hit) begin
        flag <= 1'b1;
      end else if (clear) begin
        flag <= 1'b0;
      end
    end
  end
endmodule // cia_edge_cell
`default_nettype wire

// ### cia_irq_aggregator.v
// interrupt aggregator top: sources, flags, masks, request and activity detect config
`include "cia_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cia_irq_aggregator #(
  parameter NUM_GPIO = 5,
  parameter DB_CYCLES = `CIA_DB_CYCLES
) (
  input wire ref_clk,
  input wire rstn,
  input wire [`CIA_ADDR_W-1:0] reg_addr,
  input wire [15:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [15:0] reg_rdata,
  input wire [NUM_GPIO-1:0] gpio_in,
  input wire jack_detect,
  input wire temp_warn,
  input wire temp_shut,
  input wire dc_servo_done,
  input wire fll1_lock,
  input wire fll2_lock,
  input wire src1_lock,
  input wire src2_lock,
  input wire mic_detect,
  input wire aif1_activity,
  input wire aif2_activity,
  input wire fifo_underflow,
  input wire fifo_overflow,
  output reg irq_out,
  output reg fifo_error,
  output reg gpio_fn_out,
  output reg activity_detect_enable,
  output reg activity_threshold_mode,
  output reg [4:0] activity_rms_threshold,
  output reg [1:0] activity_crest_threshold
);
  // ===========================================
  // source list: bit index in flag word 1 (gpio, jack) and word 2
  localparam NSRC = 17;
  // flag word 1 bits 0,5,7..10 ; word 2 bits 0,1,5..9,11,12,14,15
  // cell index of each source, lowest first as packed into src_in
  localparam S_GP0 = 0;
  localparam S_GP1 = 1;
  localparam S_GP2 = 2;
  localparam S_GP3 = 3;
  localparam S_GP4 = 4;
  localparam S_JACK = 5;
  localparam S_DCS = 6;
  localparam S_FIFO = 7;
  localparam S_ACT2 = 8;
  localparam S_ACT1 = 9;
  localparam S_SRC2 = 10;
  localparam S_SRC1 = 11;
  localparam S_FLL2 = 12;
  localparam S_FLL1 = 13;
  localparam S_MIC = 14;
  localparam S_SHUT = 15;
  localparam S_WARN = 16;
  // rising-only: dc servo, fifo, both activity detects, mic
  localparam [NSRC-1:0] RISE_ONLY = 17'h043C0;
  wire [NSRC-1:0] src_in;
  wire [NSRC-1:0] src_flag;
  wire [NSRC-1:0] src_level;
  wire [NSRC-1:0] src_clear;
  wire [NSRC-1:0] src_db;
  reg [15:0] mask1;
  reg [15:0] mask2;
  reg global_request_mask;
  reg [1:0] db_sel;
  reg [1:0] gpio_sel;
  reg [1:0] fifo_sync;
  reg fifo_err_sync;
  wire wr_flag1 = reg_wr && reg_addr == `CIA_REG_FLAG1;
  wire wr_flag2 = reg_wr && reg_addr == `CIA_REG_FLAG2;

  // ===========================================
  // FIFO error: rate mismatch seen as either side slipping
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      fifo_sync <= 2'h0;
      fifo_err_sync <= 1'b0;
      fifo_error <= 1'b0;
    end else begin
      fifo_sync[0] <= fifo_underflow | fifo_overflow;
      fifo_sync[1] <= fifo_sync[0];
      fifo_err_sync <= fifo_sync[1];
      fifo_error <= fifo_sync[1];
    end
  end

  // ===========================================
  // map each source to its input, flag bit and debounce control
  assign src_in = {temp_warn, temp_shut, mic_detect, fll1_lock, fll2_lock,
                   src1_lock, src2_lock, aif1_activity, aif2_activity,
                   fifo_err_sync, dc_servo_done, jack_detect, gpio_in};
  // the fifo source already passed three flops above; resyncing costs only latency
  assign src_clear = {wr_flag2 & reg_wdata[15], wr_flag2 & reg_wdata[0],
                      wr_flag2 & reg_wdata[1], wr_flag2 & reg_wdata[5],
                      wr_flag2 & reg_wdata[6], wr_flag2 & reg_wdata[7],
                      wr_flag2 & reg_wdata[8], wr_flag2 & reg_wdata[9],
                      wr_flag2 & reg_wdata[11], wr_flag2 & reg_wdata[12],
                      wr_flag2 & reg_wdata[14], wr_flag1 & reg_wdata[5],
                      wr_flag1 & reg_wdata[10], wr_flag1 & reg_wdata[9],
                      wr_flag1 & reg_wdata[8], wr_flag1 & reg_wdata[7],
                      wr_flag1 & reg_wdata[0]};
  assign src_db = {db_sel[`CIA_DB_WARN_BIT], db_sel[`CIA_DB_SHUT_BIT],
                   {(NSRC-2){1'b0}}};

  // edge choice per cell comes from the rising-only mask above
  genvar gi;
  generate
    for (gi = 0; gi < NSRC; gi = gi + 1) begin : g_src
      cia_edge_cell #(
        .BOTH_EDGES(RISE_ONLY[gi] ? 0 : 1),
        .DB_CYCLES(DB_CYCLES)
      ) u_cell (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .src_async(src_in[gi]),
        .db_enable(src_db[gi]),
        .clear(src_clear[gi]),
        .flag(src_flag[gi]),
        .level(src_level[gi])
      );
    end
  endgenerate

  // ===========================================
  // flag words as seen by software
  wire [15:0] flag1 = {5'h00,
                       src_flag[S_GP4],
                       src_flag[S_GP3],
                       src_flag[S_GP2],
                       src_flag[S_GP1],
                       1'b0,
                       src_flag[S_JACK],
                       4'h0,
                       src_flag[S_GP0]};
  wire [15:0] flag2 = {src_flag[S_WARN],
                       src_flag[S_DCS],
                       1'b0,
                       src_flag[S_FIFO],
                       src_flag[S_ACT2],
                       1'b0,
                       src_flag[S_ACT1],
                       src_flag[S_SRC2],
                       src_flag[S_SRC1],
                       src_flag[S_FLL2],
                       src_flag[S_FLL1],
                       3'h0,
                       src_flag[S_MIC],
                       src_flag[S_SHUT]};
  // raw levels are the filtered ones, so they agree with what set the flag
  wire [15:0] raw2 = {src_level[S_WARN],
                      src_level[S_DCS],
                      1'b0,
                      src_level[S_FIFO],
                      src_level[S_ACT2],
                      1'b0,
                      src_level[S_ACT1],
                      src_level[S_SRC2],
                      src_level[S_SRC1],
                      src_level[S_FLL2],
                      src_level[S_FLL1],
                      3'h0,
                      src_level[S_MIC],
                      1'b0};
  wire pending = |(flag1 & ~mask1) | |(flag2 & ~mask2);
  wire [15:0] drc_cfg = {activity_rms_threshold, activity_crest_threshold, 1'b0,
                         activity_threshold_mode, activity_detect_enable, 6'h00};

  // ===========================================
  // register writes
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      mask1 <= `CIA_MASK_RST;
      mask2 <= `CIA_MASK_RST;
      global_request_mask <= 1'b0;
      db_sel <= 2'h0;
      gpio_sel <= 2'h0;
      activity_rms_threshold <= 5'h00;
      activity_crest_threshold <= 2'h0;
      activity_threshold_mode <= 1'b1;
      activity_detect_enable <= 1'b0;
    end else if (reg_wr) begin
      case (reg_addr)
        `CIA_REG_MASK1: mask1 <= reg_wdata & `CIA_FLAG1_MASK;
        `CIA_REG_MASK2: mask2 <= reg_wdata & `CIA_FLAG2_MASK;
        `CIA_REG_CTRL: global_request_mask <= reg_wdata[`CIA_CTRL_GMASK_BIT];
        `CIA_REG_DEBOUNCE: db_sel <= reg_wdata[1:0];
        `CIA_REG_GPIO_SEL: gpio_sel <= reg_wdata[1:0];
        `CIA_REG_DRC_CFG: begin
          activity_rms_threshold <= reg_wdata[`CIA_DRC_RMS_HI:`CIA_DRC_RMS_LO];
          activity_crest_threshold <= reg_wdata[`CIA_DRC_PK_HI:`CIA_DRC_PK_LO];
          activity_threshold_mode <= reg_wdata[`CIA_DRC_MODE_BIT];
          activity_detect_enable <= reg_wdata[`CIA_DRC_ENA_BIT];
        end
        default: begin
        end
      endcase
    end
  end

  // ===========================================
  // read data one cycle after the strobe; unmapped reads zero
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        `CIA_REG_FLAG1: reg_rdata <= flag1;
        `CIA_REG_FLAG2: reg_rdata <= flag2;
        `CIA_REG_RAW2: reg_rdata <= raw2;
        `CIA_REG_MASK1: reg_rdata <= mask1;
        `CIA_REG_MASK2: reg_rdata <= mask2;
        `CIA_REG_CTRL: reg_rdata <= {15'h0000, global_request_mask};
        `CIA_REG_DEBOUNCE: reg_rdata <= {14'h0000, db_sel};
        `CIA_REG_GPIO_SEL: reg_rdata <= {14'h0000, gpio_sel};
        `CIA_REG_DRC_CFG: reg_rdata <= drc_cfg;
        default: reg_rdata <= 16'h0000;
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

  // ===========================================
  // request line and GPIO function select
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      irq_out <= 1'b0;
      gpio_fn_out <= 1'b0;
    end else begin
      irq_out <= pending & ~global_request_mask;
      case (gpio_sel)
        `CIA_GPIO_FN_IRQ: gpio_fn_out <= pending & ~global_request_mask;
        `CIA_GPIO_FN_FIFO: gpio_fn_out <= fifo_sync[1];
        default: gpio_fn_out <= 1'b0;
      endcase
    end
  end
endmodule // cia_irq_aggregator
`default_nettype wire

// ### cia_irq_checker.sv
// port-level assertions for the interrupt aggregator
`include "cia_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cia_irq_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [`CIA_ADDR_W-1:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic fifo_underflow,
  input wire logic fifo_overflow,
  input wire logic irq_out,
  input wire logic fifo_error,
  input wire logic gpio_fn_out,
  input wire logic activity_detect_enable,
  input wire logic activity_threshold_mode,
  input wire logic [4:0] activity_rms_threshold,
  input wire logic [1:0] activity_crest_threshold
);
  // ====
  // shadow of control bits, rebuilt from bus writes
  logic gmask;
  logic [1:0] gsel;
  logic [2:0] age;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      gmask <= 1'b0;
      gsel <= 2'h0;
      age <= 3'h0;
    end else begin
      if (age != 3'h7) age <= age + 3'h1;
      if (reg_wr && reg_addr == `CIA_REG_CTRL) gmask <= reg_wdata[0];
      if (reg_wr && reg_addr == `CIA_REG_GPIO_SEL) gsel <= reg_wdata[1:0];
    end
  end
  // ====
  // properties
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence s_cfg_wr; reg_wr && reg_addr == `CIA_REG_DRC_CFG; endsequence
  sequence s_cfg_rd; reg_rd && reg_addr == `CIA_REG_DRC_CFG; endsequence
  sequence s_irq_up; gsel == 2'h1 && $rose(irq_out); endsequence
  property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 16'h0000; endproperty
  property p_rd_hole; $past(reg_rd) && $past(reg_addr) == 12'h7FF |-> reg_rdata == 16'h0000;
  endproperty
  property p_cfg_thr; s_cfg_wr |=> activity_rms_threshold == $past(reg_wdata[15:11])
    && activity_crest_threshold == $past(reg_wdata[10:9]); endproperty
  property p_cfg_bits; s_cfg_wr |=> activity_threshold_mode == $past(reg_wdata[7])
    && activity_detect_enable == $past(reg_wdata[6]); endproperty
  property p_cfg_read; s_cfg_rd |=> reg_rdata == {activity_rms_threshold,
    activity_crest_threshold, 1'b0, activity_threshold_mode, activity_detect_enable, 6'h00};
  endproperty
  property p_fifo_lvl; age > 3'h4 |-> fifo_error == $past(fifo_underflow | fifo_overflow, 3);
  endproperty
  property p_gmask; gmask && $past(gmask) |-> !irq_out; endproperty
  // a request only drops after a clear, a mask or the global mask was written
  property p_irq_fall; $fell(irq_out) |-> $past(reg_wr) || $past(reg_wr, 2); endproperty
  property p_gpio_irq; s_irq_up |-> ##[0:2] gpio_fn_out; endproperty
  property p_gpio_fifo; gsel == 2'h2 && $rose(fifo_error) |-> ##[0:2] gpio_fn_out; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  a_rd_hole: assert property (p_rd_hole) else $error("unmapped read not zero");
  a_cfg_thr: assert property (p_cfg_thr) else $error("threshold fields wrong");
  a_cfg_bits: assert property (p_cfg_bits) else $error("mode or enable wrong");
  a_cfg_read: assert property (p_cfg_read) else $error("config readback wrong");
  a_fifo_lvl: assert property (p_fifo_lvl) else $error("fifo error level wrong");
  a_gmask: assert property (p_gmask) else $error("request seen under global mask");
  a_irq_fall: assert property (p_irq_fall) else $error("request dropped by itself");
  a_gpio_irq: assert property (p_gpio_irq) else $error("request not on pin");
  a_gpio_fifo: assert property (p_gpio_fifo) else $error("fifo error not on pin");
endmodule // cia_irq_checker
bind cia_irq_aggregator cia_irq_checker u_chk (.ref_clk(ref_clk), .rstn(rstn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .fifo_underflow(fifo_underflow), .fifo_overflow(fifo_overflow),
  .irq_out(irq_out), .fifo_error(fifo_error), .gpio_fn_out(gpio_fn_out),
  .activity_detect_enable(activity_detect_enable),
  .activity_threshold_mode(activity_threshold_mode),
  .activity_rms_threshold(activity_rms_threshold),
  .activity_crest_threshold(activity_crest_threshold));
`default_nettype wire

// ### cia_host_model.sv
// host side: counts request assertions seen on its interrupt pin
`timescale 1ns/1ps
`default_nettype none
module cia_host_model (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic irq_line,
  output logic [7:0] irq_seen
);
  logic line_q;
  always @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      line_q <= 1'b0;
      irq_seen <= 8'h00;
    end else begin
      line_q <= irq_line;
      if (irq_line && !line_q) irq_seen <= irq_seen + 8'h01;
    end
  end
endmodule // cia_host_model
`default_nettype wire

// ### cia_irq_aggregator_tb.sv
// self-checking bench for the interrupt aggregator
`include "cia_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module cia_irq_aggregator_tb;
  logic ref_clk = 1'b0;
  logic rstn = 1'b0;
  logic [11:0] reg_addr = 12'h000;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  // upper half feeds status 2 sources, lower half status 1, bit for bit
  logic [31:0] src = 32'h0000_0000;
  logic fovf = 1'b0;
  logic [15:0] reg_rdata, rdv, d;
  logic irq_out, fifo_error, gpio_fn_out, ena, mode;
  logic [4:0] rms;
  logic [1:0] crest;
  logic [7:0] irq_seen;
  logic [31:0] seed = 32'd21;
  int err_total = 0;
  int cmp_count = 0;
  int cyc = 0;
  always #20 ref_clk = ~ref_clk;
  cia_irq_aggregator #(.NUM_GPIO(5), .DB_CYCLES(4)) i_dut (.ref_clk(ref_clk), .rstn(rstn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .gpio_in({src[10:7], src[0]}), .jack_detect(src[5]),
    .temp_warn(src[31]), .temp_shut(src[16]), .dc_servo_done(src[30]), .fll1_lock(src[21]),
    .fll2_lock(src[22]), .src1_lock(src[23]), .src2_lock(src[24]), .mic_detect(src[17]),
    .aif1_activity(src[25]), .aif2_activity(src[27]), .fifo_underflow(src[28]),
    .fifo_overflow(fovf), .irq_out(irq_out), .fifo_error(fifo_error),
    .gpio_fn_out(gpio_fn_out), .activity_detect_enable(ena), .activity_threshold_mode(mode),
    .activity_rms_threshold(rms), .activity_crest_threshold(crest));
  cia_host_model u_host (.ref_clk(ref_clk), .rstn(rstn), .irq_line(gpio_fn_out),
    .irq_seen(irq_seen));
  // ====
  // bus, compare and stimulus helpers
  function automatic logic [15:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[15:0];
  endfunction
  task automatic test_done();
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_total++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [15:0] v);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [11:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 rdv = reg_rdata;
  endtask
  task automatic irq_is(input logic x);
    repeat (3) @(posedge ref_clk);
    #1 chk({15'h0000, irq_out}, {15'h0000, x});
  endtask
  // each source: raise, check, zero-write, clear, then lower and repeat
  task automatic edges(input logic [11:0] fa, input int base, input logic [15:0] fm,
                       input logic [15:0] bo);
    logic [15:0] b;
    logic [15:0] e;
    for (int i = 0; i < 16; i++) begin
      b = 16'h0001 << i;
      for (int lv = 1; lv >= 0 && (fm & b) != 16'h0000; lv--) begin
        e = (lv == 1 || (bo & b) != 16'h0000) ? b : 16'h0000;
        @(posedge ref_clk);
        src[base + i] <= lv[0];
        repeat (12) @(posedge ref_clk);
        rd(fa);
        chk(rdv & b, e);
        rd(`CIA_REG_RAW2);
        if (base == 16) chk(rdv & b & 16'hDBE0, lv[0] ? b & 16'hDBE0 : 16'h0000);
        wr(fa, 16'h0000);
        rd(fa);
        chk(rdv & b, e);
        wr(fa, b);
        rd(fa);
        chk(rdv & b, 16'h0000);
      end
    end
  endtask
  // ====
  // main sequence
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      test_done();
    end
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    rstn <= 1'b1;
    rd(`CIA_REG_DRC_CFG);
    chk(rdv, `CIA_DRC_CFG_RST);
    wr(12'h7FF, 16'hFFFF);
    rd(12'h7FF);
    chk(rdv, 16'h0000);
    for (int i = 0; i < 8; i++) begin
      d = (i == 0) ? 16'hFFFF : xs();
      wr(`CIA_REG_DRC_CFG, d);
      rd(`CIA_REG_DRC_CFG);
      chk(rdv, d & `CIA_DRC_CFG_MASK);
      chk({rms, crest, 1'b0, mode, ena, 6'h00}, d & `CIA_DRC_CFG_MASK);
    end
    edges(`CIA_REG_FLAG1, 0, `CIA_FLAG1_MASK, 16'hFFFF);
    edges(`CIA_REG_FLAG2, 16, `CIA_FLAG2_MASK, 16'h81E1);
    // temperature debounce: a two-cycle blip is dropped, a held level sets the flags
    wr(`CIA_REG_DEBOUNCE, 16'h0003);
    {src[31], src[16]} <= 2'h3;
    repeat (2) @(posedge ref_clk);
    {src[31], src[16]} <= 2'h0;
    repeat (12) @(posedge ref_clk);
    rd(`CIA_REG_FLAG2);
    chk(rdv & 16'h8001, 16'h0000);
    {src[31], src[16]} <= 2'h3;
    repeat (12) @(posedge ref_clk);
    rd(`CIA_REG_FLAG2);
    chk(rdv & 16'h8001, 16'h8001);
    {src[31], src[16]} <= 2'h0;
    repeat (12) @(posedge ref_clk);
    wr(`CIA_REG_FLAG2, 16'h8001);
    rd(`CIA_REG_FLAG2);
    chk(rdv & 16'h8001, 16'h0000);
    wr(`CIA_REG_MASK1, 16'h0000);
    wr(`CIA_REG_MASK2, 16'h0000);
    wr(`CIA_REG_GPIO_SEL, {14'h0000, `CIA_GPIO_FN_IRQ});
    src[22:21] <= 2'h3;
    repeat (12) @(posedge ref_clk);
    irq_is(1'b1);
    wr(`CIA_REG_FLAG2, 16'h0020);
    irq_is(1'b1);
    wr(`CIA_REG_CTRL, 16'h0001);
    irq_is(1'b0);
    wr(`CIA_REG_CTRL, 16'h0000);
    irq_is(1'b1);
    wr(`CIA_REG_MASK2, 16'h0040);
    irq_is(1'b0);
    wr(`CIA_REG_MASK2, 16'h0000);
    irq_is(1'b1);
    wr(`CIA_REG_FLAG2, 16'h0040);
    irq_is(1'b0);
    chk({8'h00, irq_seen}, 16'h0003);
    wr(`CIA_REG_GPIO_SEL, {14'h0000, `CIA_GPIO_FN_FIFO});
    fovf <= 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 chk({15'h0000, gpio_fn_out}, 16'h0001);
    chk({15'h0000, fifo_error}, 16'h0001);
    @(posedge ref_clk);
    fovf <= 1'b0;
    repeat (8) @(posedge ref_clk);
    rd(`CIA_REG_FLAG2);
    chk(rdv & 16'h1000, 16'h1000);
    test_done();
  end
endmodule // cia_irq_aggregator_tb
`default_nettype wire
